// ==== hdl/cgc_clock_gen_control.sv ====
// Control registers of the on-chip clock generator, reached over APB.
// Assumes analog status inputs are asynchronous; enable and off-mode come from the bus clock.
//
// Decided for this implementation: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module cgc_clock_gen_control
  import cgc_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic off_mode,
  input wire logic enable_in,
  input wire logic ext_stable_in,
  input wire logic lock_lost_in,
  input wire logic clock_lost_in,
  input wire logic locked_in,
  output logic osc_high_gain,
  output logic ref_crystal,
  output logic pin_reserved,
  output logic [6:0] fll_prescale,
  output logic [1:0] active_mode,
  output logic osc_enable,
  output logic loc_detect_en,
  output logic [4:0] mult_factor,
  output logic [7:0] divide_ratio,
  output logic irq_req,
  output logic reset_req
);

  // ----------------------------------------
  // Factor decoding
  // ----------------------------------------
  function automatic logic [4:0] mult_of(input logic [2:0] code);
    mult_of = MULT_BASE + {1'b0, code, 1'b0};
  endfunction : mult_of

  function automatic logic [7:0] div_of(input logic [2:0] code);
    div_of = DIV_ONE << code;
  endfunction : div_of

  function automatic logic [CNT_W-1:0] sync_load(input logic dummy);
    sync_load = CNT_W'(FIELD_SYNC_CYCLES) | {{(CNT_W-1){1'b0}}, dummy};
  endfunction : sync_load

  // ----------------------------------------
  // State
  // ----------------------------------------
  cgc_ctrl_one_t c1_reg;
  cgc_ctrl_two_t c2_reg;
  cgc_events_t s1_reg, s2_reg, s3_reg, clean_reg, prev_reg;
  cgc_mode_state_t ms_reg;
  logic first_done_reg;
  logic internal_lock_reg;
  logic [CNT_W-1:0] mode_cnt_reg, mfd_cnt_reg, rfd_cnt_reg;
  logic lol_stat_reg, loc_stat_reg;
  logic [1:0] mode_stat_reg;
  logic pready_reg, pslverr_reg;
  logic [31:0] prdata_reg;
  logic gain_reg, refc_reg, pinres_reg, osc_en_reg, locen_reg;
  logic [6:0] presc_reg;
  logic [4:0] mult_reg;
  logic [7:0] div_reg;
  logic irq_reg, rst_req_reg;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  logic setup_acc, done_acc, wr_c1, wr_c2, wr_st, hit;
  logic mode_busy, mode_ok, ext_req;
  logic [7:0] status_byte;

  assign setup_acc = psel && penable && !pready_reg;
  assign done_acc = psel && penable && pready_reg;
  assign wr_c1 = done_acc && pwrite && paddr == ADDR_CTRL_ONE;
  assign wr_c2 = done_acc && pwrite && paddr == ADDR_CTRL_TWO;
  assign wr_st = done_acc && pwrite && paddr == ADDR_STATUS;
  assign hit = paddr == ADDR_CTRL_ONE || paddr == ADDR_CTRL_TWO || paddr == ADDR_STATUS;
  assign mode_busy = ms_reg != MS_IDLE;
  assign ext_req = pwdata[C1_MODE_HI];
  assign mode_ok = !mode_busy && !(first_done_reg && internal_lock_reg && ext_req);
  assign status_byte = {mode_stat_reg, refc_reg, lol_stat_reg, clean_reg.locked,
                        loc_stat_reg, clean_reg.ext_stable, 1'b0};

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= RDATA_ZERO;
    end else if (ce) begin
      pready_reg <= setup_acc;
      if (setup_acc) begin
        pslverr_reg <= !hit;
        case (paddr)
          ADDR_CTRL_ONE: prdata_reg <= {24'h00_0000, c1_reg};
          ADDR_CTRL_TWO: prdata_reg <= {24'h00_0000, c2_reg};
          ADDR_STATUS: prdata_reg <= {24'h00_0000, status_byte};
          default: prdata_reg <= RDATA_ZERO;
        endcase
      end else begin
        pslverr_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      clean_reg <= '0;
      prev_reg <= '0;
    end else if (ce) begin
      s1_reg <= {ext_stable_in, lock_lost_in, clock_lost_in, locked_in};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      clean_reg <= (s2_reg & s3_reg) | (clean_reg & (s2_reg | s3_reg));
      prev_reg <= clean_reg;
    end
  end

  // ----------------------------------------
  // Control one
  // ----------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      c1_reg <= CTRL_ONE_RST;
      first_done_reg <= 1'b0;
      internal_lock_reg <= 1'b0;
    end else if (ce && wr_c1) begin
      if (!first_done_reg) begin
        c1_reg.gain <= pwdata[C1_GAIN_BIT];
        c1_reg.range <= pwdata[C1_RANGE_BIT];
        c1_reg.ref_crystal <= pwdata[C1_REF_BIT];
        first_done_reg <= 1'b1;
        internal_lock_reg <= !ext_req;
      end
      if (mode_ok) begin
        c1_reg.mode <= pwdata[C1_MODE_HI:C1_MODE_LO];
      end
      c1_reg.stop_en <= pwdata[C1_STOP_BIT];
      c1_reg.loc_disable <= pwdata[C1_LOSS_OF_CLOCK_DISABLE_BIT];
    end
  end

  // ----------------------------------------
  // Mode switching
  // ----------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ms_reg <= MS_IDLE;
      mode_cnt_reg <= '0;
      mode_stat_reg <= MODE_SELF_CLOCKED;
    end else if (ce) begin
      case (ms_reg)
        MS_IDLE: begin
          if (wr_c1 && mode_ok) begin
            ms_reg <= MS_SYNC;
            mode_cnt_reg <= sync_load(1'b0);
          end
        end
        MS_SYNC: begin
          if (off_mode) begin
            ms_reg <= MS_SYNC;
          end else if (mode_cnt_reg > CNT_W'(1)) begin
            mode_cnt_reg <= mode_cnt_reg - CNT_W'(1);
          end else if (c1_reg.mode == MODE_FLL_BYP_EXT && !clean_reg.ext_stable) begin
            ms_reg <= MS_WAIT_REF;
          end else begin
            mode_stat_reg <= c1_reg.mode;
            ms_reg <= MS_IDLE;
          end
        end
        MS_WAIT_REF: begin
          if (clean_reg.ext_stable && !off_mode) begin
            mode_stat_reg <= c1_reg.mode;
            ms_reg <= MS_IDLE;
          end
        end
        default: ms_reg <= MS_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Control two and pending factors
  // ----------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      c2_reg <= CTRL_TWO_RST;
      mfd_cnt_reg <= '0;
      rfd_cnt_reg <= '0;
    end else if (ce) begin
      if (wr_c2) begin
        c2_reg.lol_reset_en <= pwdata[C2_LOSS_OF_LOCK_RESET_ENABLE_BIT];
        c2_reg.loc_reset_en <= pwdata[C2_LOSS_OF_CLOCK_RESET_ENABLE_BIT];
      end
      if (wr_c2 && mfd_cnt_reg == '0) begin
        c2_reg.mult <= pwdata[C2_MFD_HI:C2_MFD_LO];
        mfd_cnt_reg <= sync_load(1'b0);
      end else if (mfd_cnt_reg != '0) begin
        mfd_cnt_reg <= mfd_cnt_reg - CNT_W'(1);
      end
      if (wr_c2 && rfd_cnt_reg == '0) begin
        c2_reg.div <= pwdata[C2_RFD_HI:C2_RFD_LO];
        rfd_cnt_reg <= sync_load(1'b0);
      end else if (rfd_cnt_reg != '0) begin
        rfd_cnt_reg <= rfd_cnt_reg - CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mult_reg <= mult_of(CTRL_TWO_RST[C2_MFD_HI:C2_MFD_LO]);
      div_reg <= div_of(CTRL_TWO_RST[C2_RFD_HI:C2_RFD_LO]);
    end else if (ce) begin
      if (mfd_cnt_reg == CNT_W'(1)) begin
        mult_reg <= mult_of(c2_reg.mult);
      end
      if (rfd_cnt_reg == CNT_W'(1)) begin
        div_reg <= div_of(c2_reg.div);
      end
    end
  end

  // ----------------------------------------
  // Loss of lock and loss of clock
  // ----------------------------------------
  logic lol_rise, loc_rise;
  assign lol_rise = clean_reg.lock_lost && !prev_reg.lock_lost;
  assign loc_rise = clean_reg.clock_lost && !prev_reg.clock_lost && !c1_reg.loc_disable;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      lol_stat_reg <= 1'b0;
      loc_stat_reg <= 1'b0;
    end else if (ce) begin
      if (lol_rise) begin
        lol_stat_reg <= 1'b1;
      end else if (wr_st && pwdata[ST_LOSS_OF_LOCK_STATUS_BIT]) begin
        lol_stat_reg <= 1'b0;
      end
      if (loc_rise) begin
        loc_stat_reg <= 1'b1;
      end else if (wr_st && pwdata[ST_LOSS_OF_CLOCK_STATUS_BIT]) begin
        loc_stat_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      irq_reg <= 1'b0;
      rst_req_reg <= 1'b0;
    end else if (ce) begin
      irq_reg <= (lol_stat_reg && !c2_reg.lol_reset_en)
              || (loc_stat_reg && !c2_reg.loc_reset_en);
      rst_req_reg <= (lol_stat_reg && c2_reg.lol_reset_en)
                  || (loc_stat_reg && c2_reg.loc_reset_en);
    end
  end

  // ----------------------------------------
  // Oscillator and clock path controls
  // ----------------------------------------
  logic ext_active, stop_eff, osc_next;
  assign ext_active = mode_stat_reg[1];
  assign stop_eff = c1_reg.stop_en && !(c1_reg.gain && c1_reg.range);

  always_comb begin
    osc_next = ext_active;
    if (off_mode) begin
      if (stop_eff) begin
        osc_next = c1_reg.mode[1] && refc_reg;
      end else begin
        osc_next = enable_in && c1_reg.mode == MODE_FLL_BYP_EXT && refc_reg;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      gain_reg <= 1'b0;
      refc_reg <= 1'b0;
      pinres_reg <= 1'b0;
      presc_reg <= PRESCALE_LOW_RANGE;
      osc_en_reg <= 1'b0;
      locen_reg <= !CTRL_ONE_RST[C1_LOSS_OF_CLOCK_DISABLE_BIT];
    end else if (ce) begin
      gain_reg <= c1_reg.gain;
      refc_reg <= c1_reg.ref_crystal;
      pinres_reg <= first_done_reg && !internal_lock_reg;
      presc_reg <= (ext_active && c1_reg.range) ? PRESCALE_HIGH_RANGE
                                                 : PRESCALE_LOW_RANGE;
      osc_en_reg <= osc_next;
      locen_reg <= !c1_reg.loc_disable;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign pready = pready_reg;
  assign prdata = prdata_reg;
  assign pslverr = pslverr_reg;
  assign osc_high_gain = gain_reg;
  assign ref_crystal = refc_reg;
  assign pin_reserved = pinres_reg;
  assign fll_prescale = presc_reg;
  assign active_mode = mode_stat_reg;
  assign osc_enable = osc_en_reg;
  assign loc_detect_en = locen_reg;
  assign mult_factor = mult_reg;
  assign divide_ratio = div_reg;
  assign irq_req = irq_reg;
  assign reset_req = rst_req_reg;

endmodule : cgc_clock_gen_control

// ==== hdl/cgc_pkg.sv ====
// Constants, field layouts and carrier types of the clock generator control block.
// Assumes a 32-bit APB master and a 100 MHz bus clock.
package cgc_pkg;

  // ----------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] ADDR_CTRL_ONE = 8'h00;
  localparam logic [7:0] ADDR_CTRL_TWO = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] CTRL_ONE_RST = 8'h00;
  localparam logic [7:0] CTRL_TWO_RST = 8'h00;
  localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int C1_GAIN_BIT = 7;
  localparam int C1_RANGE_BIT = 6;
  localparam int C1_REF_BIT = 5;
  localparam int C1_MODE_HI = 4;
  localparam int C1_MODE_LO = 3;
  localparam int C1_STOP_BIT = 2;
  localparam int C1_LOSS_OF_CLOCK_DISABLE_BIT = 1;
  localparam int C2_LOSS_OF_LOCK_RESET_ENABLE_BIT = 7;
  localparam int C2_MFD_HI = 6;
  localparam int C2_MFD_LO = 4;
  localparam int C2_LOSS_OF_CLOCK_RESET_ENABLE_BIT = 3;
  localparam int C2_RFD_HI = 2;
  localparam int C2_RFD_LO = 0;
  localparam int ST_LOSS_OF_LOCK_STATUS_BIT = 4;
  localparam int ST_LOSS_OF_CLOCK_STATUS_BIT = 2;

  // ----------------------------------------
  // Clock modes
  // ----------------------------------------
  localparam logic [1:0] MODE_SELF_CLOCKED = 2'h0;
  localparam logic [1:0] MODE_FLL_INT = 2'h1;
  localparam logic [1:0] MODE_FLL_BYP_EXT = 2'h2;
  localparam logic [1:0] MODE_FLL_EXT = 2'h3;

  // ----------------------------------------
  // FLL prescale and factor arithmetic
  // ----------------------------------------
  localparam logic [6:0] PRESCALE_LOW_RANGE = 7'h40;
  localparam logic [6:0] PRESCALE_HIGH_RANGE = 7'h01;
  localparam logic [4:0] MULT_BASE = 5'h04;
  localparam logic [7:0] DIV_ONE = 8'h01;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int FIELD_SYNC_NS = 50;
  localparam int FIELD_SYNC_CYCLES = (FIELD_SYNC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 4;

  // ----------------------------------------
  // Carrier types
  // ----------------------------------------
  typedef struct packed {
    logic gain;
    logic range;
    logic ref_crystal;
    logic [1:0] mode;
    logic stop_en;
    logic loc_disable;
    logic unused;
  } cgc_ctrl_one_t;

  typedef struct packed {
    logic lol_reset_en;
    logic [2:0] mult;
    logic loc_reset_en;
    logic [2:0] div;
  } cgc_ctrl_two_t;

  typedef struct packed {
    logic ext_stable;
    logic lock_lost;
    logic clock_lost;
    logic locked;
  } cgc_events_t;

  typedef enum logic [1:0] {
    MS_IDLE,
    MS_SYNC,
    MS_WAIT_REF
  } cgc_mode_state_t;

endpackage : cgc_pkg

// ==== testbench/cgc_props.sv ====
// Port checker for the clock generator control block.
// Assumes it is bound to cgc_clock_gen_control and that ce stays high.
`timescale 1ns/1ps
module cgc_props
  import cgc_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic osc_high_gain,
  input wire logic ref_crystal,
  input wire logic pin_reserved,
  input wire logic loc_detect_en,
  input wire logic [6:0] fll_prescale,
  input wire logic [1:0] active_mode,
  input wire logic [4:0] mult_factor,
  input wire logic [7:0] divide_ratio
);
  // ----------------------------------------
  // Write strobes and properties
  // ----------------------------------------
  logic wr1;
  logic wr2;
  assign wr1 = psel && penable && pready && pwrite && paddr == ADDR_CTRL_ONE;
  assign wr2 = psel && penable && pready && pwrite && paddr == ADDR_CTRL_TWO;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  wait_state_a: assert property (psel && penable && !pready && ce |=> pready)
    else $error("no answer one cycle into access");
  pready_pulse_a: assert property (pready && ce |=> !pready)
    else $error("ready held longer than one cycle");
  pready_cause_a: assert property (pready |-> $past(psel && penable))
    else $error("ready without access phase");
  error_reply_a: assert property (pslverr |-> pready && prdata == RDATA_ZERO)
    else $error("error response malformed");
  prescale_range_a: assert property (fll_prescale == PRESCALE_HIGH_RANGE |->
    active_mode[1] || $past(active_mode[1])) else $error("prescale 1 outside external mode");
  mode_lockout_a: assert property (!pin_reserved |-> !active_mode[1])
    else $error("external mode without reserved pin");
  factor_delay_a: assert property ($changed({mult_factor, divide_ratio}) |->
    $past(wr2, 4) || $past(wr2, 5) || $past(wr2, 6)) else $error("factor moved without write");
  once_bits_a: assert property ($changed({osc_high_gain, ref_crystal, loc_detect_en}) |->
    $past(wr1, 2)) else $error("control bit moved without write");

  cover property (wr1);
  cover property (pslverr);
  cover property ($rose(active_mode == MODE_FLL_BYP_EXT));
endmodule : cgc_props

bind cgc_clock_gen_control cgc_props u_props (.clk(clk), .reset(reset), .ce(ce),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready),
  .prdata(prdata), .pslverr(pslverr), .osc_high_gain(osc_high_gain),
  .ref_crystal(ref_crystal), .pin_reserved(pin_reserved), .loc_detect_en(loc_detect_en),
  .fll_prescale(fll_prescale), .active_mode(active_mode), .mult_factor(mult_factor),
  .divide_ratio(divide_ratio));

// ==== testbench/clock_generator_control_regs_test.sv ====
// Self-checking bench for the clock generator control block.
// Assumes APB answers arrive in their own time and fields settle within 12 cycles.
`timescale 1ns/1ps
module clock_generator_control_regs_test;
  import cgc_pkg::*;
  logic clk, reset, ce, psel, penable, pwrite, pready, pslverr, er;
  logic off_mode, enable_in, ext_stable_in, lock_lost_in, clock_lost_in, locked_in;
  logic osc_high_gain, ref_crystal, pin_reserved, osc_enable, loc_detect_en, irq_req, reset_req;
  logic [7:0] paddr, divide_ratio;
  logic [31:0] pwdata, prdata, rd;
  logic [6:0] fll_prescale;
  logic [1:0] active_mode;
  logic [4:0] mult_factor;
  int n_errors, n_tests, cycles;

  cgc_clock_gen_control dut (.clk(clk), .reset(reset), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .off_mode(off_mode), .enable_in(enable_in),
    .ext_stable_in(ext_stable_in), .lock_lost_in(lock_lost_in),
    .clock_lost_in(clock_lost_in), .locked_in(locked_in), .osc_high_gain(osc_high_gain),
    .ref_crystal(ref_crystal), .pin_reserved(pin_reserved), .fll_prescale(fll_prescale),
    .active_mode(active_mode), .osc_enable(osc_enable), .loc_detect_en(loc_detect_en),
    .mult_factor(mult_factor), .divide_ratio(divide_ratio), .irq_req(irq_req),
    .reset_req(reset_req));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : test_done

  // One APB transfer; the request stands until pready is sampled high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    check(rd, exp);
  endtask : rdchk

  // Covers input sync, the field settle and the output register
  task automatic cyc;
    repeat (12) @(posedge clk);
    @(negedge clk);
  endtask : cyc

  task automatic do_reset;
    @(posedge clk);
    reset <= 1'b1;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    @(negedge clk);
  endtask : do_reset

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    check(32'({fll_prescale, mult_factor, divide_ratio}), 32'h0008_0401);
    check(32'({osc_high_gain, ref_crystal, pin_reserved, active_mode, osc_enable}), 0);
    check(32'({loc_detect_en, irq_req, reset_req}), 4);
    rdchk(ADDR_CTRL_ONE, 32'h0000_0000);
    rdchk(ADDR_CTRL_TWO, 32'h0000_0000);
    rdchk(8'h0C, 32'h0000_0000);
    check(32'(er), 1);
    apb(1'b1, 8'h0C, 32'hFFFF_FFFF);
    check(32'(er), 1);
    $display("done t_reset");
  endtask : t_reset

  task automatic t_once;
    apb(1'b1, ADDR_CTRL_ONE, 32'h0000_007C);
    cyc;
    check(32'({osc_high_gain, ref_crystal, pin_reserved, loc_detect_en}), 7);
    check(32'({active_mode, fll_prescale}), 32'h0000_0181);
    apb(1'b1, ADDR_CTRL_ONE, 32'h0000_0082);
    cyc;
    rdchk(ADDR_CTRL_ONE, 32'h0000_0062);
    check(32'({osc_high_gain, loc_detect_en}), 0);
    check(32'({active_mode, fll_prescale}), 32'h0000_0040);
    @(posedge clk) ext_stable_in <= 1'b0;
    cyc;
    apb(1'b1, ADDR_CTRL_ONE, 32'h0000_0010);
    cyc;
    check(32'(active_mode), 32'(MODE_SELF_CLOCKED));
    @(posedge clk) ext_stable_in <= 1'b1;
    cyc;
    check(32'(active_mode), 32'(MODE_FLL_BYP_EXT));
    @(posedge clk) off_mode <= 1'b1;
    cyc;
    check(32'(osc_enable), 1);
    rdchk(ADDR_CTRL_ONE, 32'h0000_0070);
    @(posedge clk) enable_in <= 1'b0;
    cyc;
    check(32'(osc_enable), 0);
    apb(1'b1, ADDR_CTRL_ONE, 32'h0000_0014);
    cyc;
    check(32'(osc_enable), 1);
    @(posedge clk) off_mode <= 1'b0;
    $display("done t_once");
  endtask : t_once

  task automatic t_factors;
    for (int c = 0; c < 8; c++) begin
      apb(1'b1, ADDR_CTRL_TWO, 32'((c << 4) | c));
      cyc;
      check(32'(mult_factor), 32'(4 + 2 * c));
      check(32'(divide_ratio), 32'(1 << c));
    end
    apb(1'b1, ADDR_CTRL_TWO, 32'h0000_0010);
    apb(1'b1, ADDR_CTRL_TWO, 32'h0000_0023);
    cyc;
    check(32'({mult_factor, divide_ratio}), 32'h0000_0601);
    $display("done t_factors");
  endtask : t_factors

  task automatic t_lockout;
    do_reset;
    apb(1'b1, ADDR_CTRL_ONE, 32'h0000_0088);
    cyc;
    check(32'({pin_reserved, osc_high_gain, active_mode}), 32'h0000_0005);
    apb(1'b1, ADDR_CTRL_ONE, 32'h0000_0018);
    cyc;
    rdchk(ADDR_CTRL_ONE, 32'h0000_0088);
    check(32'(active_mode), 32'(MODE_FLL_INT));
    apb(1'b1, ADDR_CTRL_TWO, 32'h0000_0008);
    @(posedge clk) lock_lost_in <= 1'b1;
    cyc;
    check(32'({irq_req, reset_req}), 2);
    rdchk(ADDR_STATUS, 32'h0000_0052);
    @(posedge clk) lock_lost_in <= 1'b0;
    apb(1'b1, ADDR_STATUS, 32'h0000_0010);
    cyc;
    check(32'({irq_req, reset_req}), 0);
    @(posedge clk) clock_lost_in <= 1'b1;
    cyc;
    check(32'({irq_req, reset_req}), 1);
    @(posedge clk) clock_lost_in <= 1'b0;
    apb(1'b1, ADDR_STATUS, 32'h0000_0004);
    apb(1'b1, ADDR_CTRL_ONE, 32'h0000_008A);
    cyc;
    @(posedge clk) clock_lost_in <= 1'b1;
    cyc;
    check(32'({irq_req, reset_req}), 0);
    $display("done t_lockout");
  endtask : t_lockout

  task automatic t_gain_range;
    @(posedge clk) clock_lost_in <= 1'b0;
    do_reset;
    apb(1'b1, ADDR_CTRL_ONE, 32'h0000_00F4);
    cyc;
    check(32'({active_mode, fll_prescale}), 32'h0000_0101);
    @(posedge clk) off_mode <= 1'b1;
    cyc;
    check(32'(osc_enable), 0);
    @(posedge clk) enable_in <= 1'b1;
    cyc;
    check(32'(osc_enable), 1);
    @(posedge clk) off_mode <= 1'b0;
    $display("done t_gain_range");
  endtask : t_gain_range

  // ----------------------------------------
  // Clock, watchdog and main sequence
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      test_done;
    end
  end

  initial begin
    {reset, ce, psel, penable, pwrite, paddr, pwdata} = {2'b11, 43'h0};
    {off_mode, enable_in, ext_stable_in, lock_lost_in, clock_lost_in, locked_in} = 6'b011000;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    @(negedge clk);
    t_reset;
    t_once;
    t_factors;
    t_lockout;
    t_gain_range;
    test_done;
  end
endmodule : clock_generator_control_regs_test
